// file: return_rotate_subtract_sleep_exec_tb_top.sv
/*
 * Self-checking bench of the execution block: a table of operations,
 * then returns, sleep, unmapped access and a second reset.
 * Assumes rrsse_pkg and rrsse_core are compiled before it.
 */
`include "rrsse_defines.svh"

module return_rotate_subtract_sleep_exec_tb_top
    import rrsse_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        rrsse_instr_t instr;
        logic [7:0]   acc;
        logic [7:0]   fdat;
        logic [5:0]   stat;
        logic [7:0]   e_acc;
        logic [7:0]   e_fdat;
        logic [5:0]   e_stat;
    } rrsse_row_t;

    logic        clk_i           = 1'b0;
    logic        resetn_i        = 1'b0;
    logic [7:0]  avs_address_i   = 8'h00;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        sleeping_o;
    logic        global_irq_enable_o;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          nwait;
    logic [31:0] q;
    rrsse_row_t  rows [11];

    rrsse_core #(
        .PRESC_W             (4)
    ) u_rrsse_core (
        .clk_i               (clk_i),
        .resetn_i            (resetn_i),
        .avs_address_i       (avs_address_i),
        .avs_read_i          (avs_read_i),
        .avs_write_i         (avs_write_i),
        .avs_writedata_i     (avs_writedata_i),
        .avs_readdata_o      (avs_readdata_o),
        .avs_waitrequest_o   (avs_waitrequest_o),
        .sleeping_o          (sleeping_o),
        .global_irq_enable_o (global_irq_enable_o)
    );

    always #2.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked,
                 num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time,
                     got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        for (nwait = 0; nwait < 50; nwait++)
        begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (nwait == 50)
        begin
            num_errors++;
            $display("wrong value at %0t: no answer on the bus", $time);
            print_verdict();
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    function automatic rrsse_instr_t mk(rrsse_op_t o, logic d,
                                        logic [7:0] l);
        rrsse_instr_t w;
        w = '{o, d, l};
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rows[0]  = '{mk(OP_SUB_FILE, 1'b0, 8'h05), 8'h30, 8'h50, 6'h18,
                     8'h20, 8'h50, 6'h1b};
        rows[1]  = '{mk(OP_SUB_FILE, 1'b1, 8'h7f), 8'h50, 8'h30, 6'h18,
                     8'h50, 8'he0, 6'h1a};
        rows[2]  = '{mk(OP_SUB_FILE, 1'b0, 8'h00), 8'h45, 8'h45, 6'h18,
                     8'h00, 8'h45, 6'h1f};
        rows[3]  = '{mk(OP_SUB_FILE, 1'b1, 8'h11), 8'h0f, 8'h81, 6'h1f,
                     8'h0f, 8'h72, 6'h19};
        rows[4]  = '{mk(OP_SUB_LIT, 1'b0, 8'h10), 8'h11, 8'h22, 6'h18,
                     8'hff, 8'h22, 6'h18};
        rows[5]  = '{mk(OP_SUB_LIT, 1'b1, 8'hff), 8'h00, 8'h22, 6'h18,
                     8'hff, 8'h22, 6'h1b};
        rows[6]  = '{mk(OP_SUB_LIT, 1'b0, 8'h00), 8'h00, 8'h22, 6'h18,
                     8'h00, 8'h22, 6'h1f};
        rows[7]  = '{mk(OP_ROT_RIGHT, 1'b0, 8'h20), 8'h33, 8'h81, 6'h18,
                     8'h40, 8'h81, 6'h19};
        rows[8]  = '{mk(OP_ROT_RIGHT, 1'b1, 8'h21), 8'h33, 8'h02, 6'h1d,
                     8'h33, 8'h81, 6'h1c};
        rows[9]  = '{mk(OP_SLEEP, 1'b0, 8'h00), 8'h5a, 8'h22, 6'h0f,
                     8'h5a, 8'h22, 6'h17};
        rows[10] = '{mk(OP_NOP, 1'b0, 8'h00), 8'h5a, 8'h22, 6'h05,
                     8'h5a, 8'h22, 6'h05};
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        rreg(`RRSSE_OFF_STATUS, 32'h18);
        rreg(`RRSSE_OFF_ACC, 32'h0);
        chk({31'h0, sleeping_o}, 32'h0);
        foreach (rows[i])
        begin
            wreg(`RRSSE_OFF_ACC, {24'h0, rows[i].acc});
            wreg(`RRSSE_OFF_FADDR, {25'h0, rows[i].instr.lit[6:0]});
            wreg(`RRSSE_OFF_FDATA, {24'h0, rows[i].fdat});
            wreg(`RRSSE_OFF_STATUS, {26'h0, rows[i].stat});
            wreg(`RRSSE_OFF_INSTR, {20'h0, rows[i].instr});
            chk(nwait, 32'h2);
            rreg(`RRSSE_OFF_ACC, {24'h0, rows[i].e_acc});
            rreg(`RRSSE_OFF_STATUS, {26'h0, rows[i].e_stat});
            rreg(`RRSSE_OFF_FDATA, {24'h0, rows[i].e_fdat});
            rreg(`RRSSE_OFF_FADDR, {25'h0, rows[i].instr.lit[6:0]});
        end
        // Returns pop the stack in order
        wreg(`RRSSE_OFF_STATUS, 32'h05);
        wreg(`RRSSE_OFF_STACK, 32'h1234);
        wreg(`RRSSE_OFF_STACK, 32'h0567);
        rreg(`RRSSE_OFF_STACK, 32'h0567);
        wreg(`RRSSE_OFF_INSTR, {20'h0, mk(OP_RET_LIT, 1'b0, 8'ha5)});
        chk(nwait, 32'h3);
        rreg(`RRSSE_OFF_PC, 32'h0567);
        rreg(`RRSSE_OFF_ACC, 32'ha5);
        wreg(`RRSSE_OFF_INSTR, {20'h0, mk(OP_RETURN, 1'b0, 8'h00)});
        chk(nwait, 32'h3);
        rreg(`RRSSE_OFF_PC, 32'h1234);
        rreg(`RRSSE_OFF_STATUS, 32'h05);
        wreg(`RRSSE_OFF_STACK, 32'h7fff);
        wreg(`RRSSE_OFF_INSTR, {20'h0, mk(OP_RET_IRQ, 1'b0, 8'h00)});
        chk(nwait, 32'h3);
        rreg(`RRSSE_OFF_PC, 32'h7fff);
        rreg(`RRSSE_OFF_INSTR, 32'h0000_0600);
        rreg(`RRSSE_OFF_STATUS, 32'h25);
        chk({31'h0, global_irq_enable_o}, 32'h1);
        // Watchdog runs, then sleep clears it and the prescaler
        repeat (100) @(posedge clk_i);
        bus(1'b0, `RRSSE_OFF_WDOG, 32'h0);
        chk({31'h0, q[7:0] != 8'h00}, 32'h1);
        wreg(`RRSSE_OFF_INSTR, {20'h0, mk(OP_SLEEP, 1'b0, 8'h00)});
        rreg(`RRSSE_OFF_WDOG, 32'h0);
        repeat (8) @(posedge clk_i);
        rreg(`RRSSE_OFF_WDOG, 32'h0);
        rreg(`RRSSE_OFF_STATUS, 32'h35);
        chk({31'h0, sleeping_o}, 32'h1);
        wreg(`RRSSE_OFF_INSTR, {20'h0, mk(OP_NOP, 1'b0, 8'h00)});
        chk({31'h0, sleeping_o}, 32'h0);
        // Unmapped places
        wreg(8'h24, 32'hff);
        rreg(8'h20, 32'h0);
        rreg(`RRSSE_OFF_ACC, 32'ha5);
        wreg(`RRSSE_OFF_PC, 32'h0042);
        rreg(`RRSSE_OFF_PC, 32'h0042);
        // Second reset in mid-run
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, avs_waitrequest_o}, 32'h1);
        resetn_i <= 1'b1;
        rreg(`RRSSE_OFF_STATUS, 32'h18);
        rreg(`RRSSE_OFF_ACC, 32'h0);
        chk({31'h0, global_irq_enable_o}, 32'h0);
        print_verdict();
    end
endmodule

// file: rrsse_core.sv
/*
 * Execution block for return, rotate, subtract and sleep operations,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes one 200 MHz clock and a master that holds its request
 * until it samples waitrequest low.
 */
// The Avalon-MM slave port and the register addresses were left to the implementer.
`include "rrsse_defines.svh"

// Function
// - Literal return loads accumulator, pops, two cycles
// - Subroutine return pops stack, flags unchanged
// - Rotate right through borrow flag
// - Rotate destination bit picks accumulator or file
// - Sleep clears watchdog counter and prescaler
// - Sleep clears power-down, sets expiry bit
// - File minus accumulator to chosen destination
// - File subtract borrow and nibble borrow flags
// - Literal minus accumulator into accumulator
// - Literal subtract borrow and nibble borrow flags
// - Interrupt return pops, enables interrupts, two cycles
module rrsse_core import rrsse_pkg::*; #(
    parameter int PC_W        = 15,
    parameter int STACK_DEPTH = 16,
    parameter int PRESC_W     = 8
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             sleeping_o,
    output logic             global_irq_enable_o
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    rrsse_state_t  state;
    rrsse_instr_t  instr;
    rrsse_status_t status;
    logic [7:0]    acc;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [`RRSSE_FADDR_W-1:0] file_addr;
    logic [7:0]    wdog;
    logic [PRESC_W-1:0] presc;
    logic [7:0]    mem_rd_data;
    logic [`RRSSE_FADDR_W-1:0] mem_rd_addr;
    logic [`RRSSE_FADDR_W-1:0] mem_wr_addr;
    logic [7:0]    mem_wr_data;
    logic          mem_wr_en;
    logic [7:0]    operand;
    logic [7:0]    diff;
    logic [7:0]    rot;
    logic [PC_W-1:0] stack_top;
    logic          take;
    rrsse_reg_t    sel;

    ////////////////////////////////////////////////////////////////////
    // Register decode, shared by read and write paths
    function automatic rrsse_reg_t reg_sel(input logic [7:0] a);
        case (a)
            `RRSSE_OFF_INSTR:  reg_sel = RG_INSTR;
            `RRSSE_OFF_ACC:    reg_sel = RG_ACC;
            `RRSSE_OFF_STATUS: reg_sel = RG_STATUS;
            `RRSSE_OFF_PC:     reg_sel = RG_PC;
            `RRSSE_OFF_STACK:  reg_sel = RG_STACK;
            `RRSSE_OFF_FDATA:  reg_sel = RG_FDATA;
            `RRSSE_OFF_FADDR:  reg_sel = RG_FADDR;
            `RRSSE_OFF_WDOG:   reg_sel = RG_WDOG;
            default:           reg_sel = RG_NONE;
        endcase
    endfunction

    assign take      = (state == ST_IDLE) && (avs_read_i || avs_write_i);
    assign sel       = reg_sel(avs_address_i);
    assign stack_top = stack[sp - SP_W'(1)];

    ////////////////////////////////////////////////////////////////////
    // Datapath
    assign operand = (instr.op == OP_SUB_LIT) ? instr.lit : mem_rd_data;
    assign diff    = operand - acc;
    assign rot     = {status.borrow_flag, mem_rd_data[7:1]};

    always_comb
    begin
        mem_rd_addr = file_addr;
        if (take && avs_write_i && sel == RG_INSTR)
        begin
            mem_rd_addr = avs_writedata_i[6:0];
        end
    end

    always_comb
    begin
        mem_wr_en   = 1'b0;
        mem_wr_addr = file_addr;
        mem_wr_data = avs_writedata_i[7:0];
        if (state == ST_EXEC && instr.dest)
        begin
            mem_wr_addr = instr.lit[6:0];
            if (instr.op == OP_ROT_RIGHT)
            begin
                mem_wr_en   = 1'b1;
                mem_wr_data = rot;
            end
            else if (instr.op == OP_SUB_FILE)
            begin
                mem_wr_en   = 1'b1;
                mem_wr_data = diff;
            end
        end
        else if (take && avs_write_i && sel == RG_FDATA)
        begin
            mem_wr_en = 1'b1;
        end
    end

    rrsse_file_mem #(
        .AW (`RRSSE_FADDR_W),
        .DW (8)
    ) u_mem (
        .clk_i     (clk_i),
        .rd_addr_i (mem_rd_addr),
        .wr_en_i   (mem_wr_en),
        .wr_addr_i (mem_wr_addr),
        .wr_data_i (mem_wr_data),
        .rd_data_o (mem_rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer and bus answer
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state             <= ST_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
            instr             <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (take && avs_write_i && sel == RG_INSTR)
                    begin
                        instr <= rrsse_instr_t'(avs_writedata_i[11:0]);
                        state <= ST_EXEC;
                    end
                    else if (take && avs_read_i && sel == RG_FDATA)
                    begin
                        state <= ST_MRD;
                    end
                    else if (take)
                    begin
                        avs_waitrequest_o <= 1'b0;
                        state             <= ST_ACK;
                        if (avs_read_i)
                        begin
                            case (sel)
                                RG_INSTR:  avs_readdata_o <= {20'h0_0000, instr};
                                RG_ACC:    avs_readdata_o <= {24'h00_0000, acc};
                                RG_STATUS: avs_readdata_o <= {26'h000_0000, status};
                                RG_PC:     avs_readdata_o <= 32'(pc);
                                RG_STACK:  avs_readdata_o <= 32'(stack_top);
                                RG_FADDR:  avs_readdata_o <= 32'(file_addr);
                                RG_WDOG:   avs_readdata_o <= {24'h00_0000, wdog};
                                default:   avs_readdata_o <= 32'h0000_0000;
                            endcase
                        end
                    end
                end
                ST_EXEC:
                begin
                    if (instr.op == OP_RET_LIT || instr.op == OP_RETURN ||
                        instr.op == OP_RET_IRQ)
                    begin
                        state <= ST_RET2;
                    end
                    else
                    begin
                        avs_waitrequest_o <= 1'b0;
                        state             <= ST_ACK;
                    end
                end
                ST_RET2, ST_MRD:
                begin
                    if (state == ST_MRD)
                    begin
                        avs_readdata_o <= {24'h00_0000, mem_rd_data};
                    end
                    avs_waitrequest_o <= 1'b0;
                    state             <= ST_ACK;
                end
                ST_ACK:
                begin
                    avs_waitrequest_o <= 1'b1;
                    state             <= ST_IDLE;
                end
                default:
                begin
                    avs_waitrequest_o <= 1'b1;
                    state             <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            acc <= `RRSSE_ACC_RST;
        end
        else if (take && avs_write_i && sel == RG_ACC)
        begin
            acc <= avs_writedata_i[7:0];
        end
        else if (state == ST_EXEC)
        begin
            case (instr.op)
                OP_RET_LIT:  acc <= instr.lit;
                OP_ROT_RIGHT: acc <= instr.dest ? acc : rot;
                OP_SUB_FILE: acc <= instr.dest ? acc : diff;
                OP_SUB_LIT:  acc <= diff;
                default:     acc <= acc;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            status <= rrsse_status_t'(`RRSSE_STATUS_RST);
        end
        else if (take && avs_write_i && sel == RG_STATUS)
        begin
            status <= rrsse_status_t'(avs_writedata_i[5:0]);
        end
        else if (state == ST_EXEC)
        begin
            case (instr.op)
                OP_ROT_RIGHT: status.borrow_flag <= mem_rd_data[0];
                OP_SLEEP:
                begin
                    status.power_down_status <= 1'b0;
                    status.expiry_status_bit <= 1'b1;
                end
                OP_SUB_FILE, OP_SUB_LIT:
                begin
                    status.borrow_flag        <= acc <= operand;
                    status.nibble_borrow_flag <= acc[3:0] <= operand[3:0];
                    status.nil_result_flag    <= diff == 8'h00;
                end
                OP_RET_IRQ: status.global_irq_enable <= 1'b1;
                default:    status <= status;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            global_irq_enable_o <= 1'b0;
            sleeping_o          <= 1'b0;
        end
        else
        begin
            global_irq_enable_o <= status.global_irq_enable;
            if (state == ST_EXEC && instr.op == OP_SLEEP)
            begin
                sleeping_o <= 1'b1;
            end
            else if (take && avs_write_i && sel == RG_INSTR)
            begin
                sleeping_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program counter and return stack
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            pc <= '0;
            sp <= '0;
        end
        else if (take && avs_write_i && sel == RG_PC)
        begin
            pc <= avs_writedata_i[PC_W-1:0];
        end
        else if (take && avs_write_i && sel == RG_STACK)
        begin
            sp <= sp + SP_W'(1);
        end
        else if (state == ST_EXEC && (instr.op == OP_RET_LIT ||
                 instr.op == OP_RETURN || instr.op == OP_RET_IRQ))
        begin
            pc <= stack_top;
            sp <= sp - SP_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (take && avs_write_i && sel == RG_STACK)
        begin
            stack[sp] <= avs_writedata_i[PC_W-1:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            file_addr <= '0;
        end
        else if (take && avs_write_i && sel == RG_FADDR)
        begin
            file_addr <= avs_writedata_i[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog counter and prescaler
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            wdog  <= `RRSSE_WDOG_CLR;
            presc <= '0;
        end
        else if (state == ST_EXEC && instr.op == OP_SLEEP)
        begin
            wdog  <= `RRSSE_WDOG_CLR;
            presc <= '0;
        end
        else
        begin
            presc <= presc + PRESC_W'(1);
            if (&presc)
            begin
                wdog <= wdog + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ret_tail;
        state == ST_RET2 ##1 state == ST_ACK ##1 state == ST_IDLE;
    endsequence

    chk_ret_lit_acc: assert property (
        state == ST_EXEC && instr.op == OP_RET_LIT |=>
        acc == $past(instr.lit) && pc == $past(stack_top) ##0 s_ret_tail)
        else $error("literal return wrong");
    chk_return_pop: assert property (
        state == ST_EXEC && instr.op == OP_RETURN |=>
        pc == $past(stack_top) && $stable(status) ##0 s_ret_tail)
        else $error("subroutine return wrong");
    chk_rot_carry: assert property (
        state == ST_EXEC && instr.op == OP_ROT_RIGHT |=>
        status.borrow_flag == $past(mem_rd_data[0]))
        else $error("rotate carry wrong");
    chk_rot_dest: assert property (
        state == ST_EXEC && instr.op == OP_ROT_RIGHT && !instr.dest |=>
        acc == {$past(status.borrow_flag), $past(mem_rd_data[7:1])})
        else $error("rotate result wrong");
    chk_sleep_wdog: assert property (
        state == ST_EXEC && instr.op == OP_SLEEP |=>
        wdog == 8'h00 ##1 presc == PRESC_W'(1))
        else $error("watchdog not cleared");
    chk_sleep_flags: assert property (
        state == ST_EXEC && instr.op == OP_SLEEP |=>
        status.expiry_status_bit && !status.power_down_status &&
        status.borrow_flag == $past(status.borrow_flag) && sleeping_o)
        else $error("sleep flags wrong");
    chk_subf_result: assert property (
        state == ST_EXEC && instr.op == OP_SUB_FILE && !instr.dest |=>
        acc == 8'($past(mem_rd_data) - $past(acc)))
        else $error("file subtract wrong");
    chk_subf_flags: assert property (
        state == ST_EXEC && instr.op == OP_SUB_FILE |=>
        status.borrow_flag == ($past(acc) <= $past(mem_rd_data)) &&
        status.nibble_borrow_flag ==
        ($past(acc[3:0]) <= $past(mem_rd_data[3:0])))
        else $error("file subtract flags wrong");
    chk_subl_result: assert property (
        state == ST_EXEC && instr.op == OP_SUB_LIT |=>
        acc == 8'($past(instr.lit) - $past(acc)) ##1 state == ST_IDLE)
        else $error("literal subtract wrong");
    chk_subl_flags: assert property (
        state == ST_EXEC && instr.op == OP_SUB_LIT |=>
        status.borrow_flag == ($past(acc) <= $past(instr.lit)) &&
        status.nibble_borrow_flag == ($past(acc[3:0]) <= $past(instr.lit[3:0])))
        else $error("literal subtract flags wrong");
    chk_nil_flag: assert property (
        state == ST_EXEC && instr.op inside {OP_SUB_FILE, OP_SUB_LIT} |=>
        status.nil_result_flag == ($past(diff) == 8'h00))
        else $error("zero flag wrong");
    chk_irq_return: assert property (
        state == ST_EXEC && instr.op == OP_RET_IRQ |=>
        status.global_irq_enable && pc == $past(stack_top) ##0 s_ret_tail
        ##0 global_irq_enable_o)
        else $error("interrupt return wrong");

endmodule

// file: rrsse_defines.svh
/*
 * Offsets, field widths and reset values of the
 * return/rotate/subtract/sleep execution block.
 * Assumes inclusion by bare name from the package and core.
 */
`ifndef RRSSE_DEFINES_SVH
`define RRSSE_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define RRSSE_OFF_INSTR     8'h00
`define RRSSE_OFF_ACC       8'h04
`define RRSSE_OFF_STATUS    8'h08
`define RRSSE_OFF_PC        8'h0c
`define RRSSE_OFF_STACK     8'h10
`define RRSSE_OFF_FDATA     8'h14
`define RRSSE_OFF_FADDR     8'h18
`define RRSSE_OFF_WDOG      8'h1c

////////////////////////////////////////////////////////////////////////
// Field widths
`define RRSSE_INSTR_W       12
`define RRSSE_STATUS_W      6
`define RRSSE_FADDR_W       7

////////////////////////////////////////////////////////////////////////
// Reset values
`define RRSSE_ACC_RST       8'h00
`define RRSSE_STATUS_RST    6'h18
`define RRSSE_WDOG_CLR      8'h00

`endif

// file: rrsse_file_mem.sv
/*
 * File register memory, one read and one write port.
 * Read data is registered: valid one clock after the address.
 */
module rrsse_file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic [AW-1:0] rd_addr_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// file: rrsse_pkg.sv
/*
 * Types of the execution block: operations, states, carriers.
 * Assumes rrsse_defines.svh is on the include path.
 */
`include "rrsse_defines.svh"

package rrsse_pkg;

    typedef enum logic [2:0] {
        OP_NOP         = 3'h0,
        OP_RET_LIT     = 3'h1,
        OP_RETURN      = 3'h2,
        OP_RET_IRQ     = 3'h3,
        OP_ROT_RIGHT   = 3'h4,
        OP_SLEEP       = 3'h5,
        OP_SUB_FILE    = 3'h6,
        OP_SUB_LIT     = 3'h7
    } rrsse_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_EXEC = 3'h1,
        ST_RET2 = 3'h2,
        ST_MRD  = 3'h3,
        ST_ACK  = 3'h4
    } rrsse_state_t;

    typedef enum logic [3:0] {
        RG_INSTR  = 4'h0,
        RG_ACC    = 4'h1,
        RG_STATUS = 4'h2,
        RG_PC     = 4'h3,
        RG_STACK  = 4'h4,
        RG_FDATA  = 4'h5,
        RG_FADDR  = 4'h6,
        RG_WDOG   = 4'h7,
        RG_NONE   = 4'hf
    } rrsse_reg_t;

    // Instruction word as written by software
    typedef struct packed {
        rrsse_op_t  op;
        logic       dest;
        logic [7:0] lit;
    } rrsse_instr_t;

    typedef struct packed {
        logic global_irq_enable;
        logic expiry_status_bit;
        logic power_down_status;
        logic nil_result_flag;
        logic nibble_borrow_flag;
        logic borrow_flag;
    } rrsse_status_t;

endpackage
